// [rtl/nvw_device.sv]
// Gauge end: command space, 32-byte block window and nonvolatile store
//
// Functional notes
// - Pack options word readable in every mode
// - Nominal capacity readable, never used internally
// - Subclass select write ignored while sealed
// - Open general mode: block select indexes blocks
// - Sealed: block 0 auth, 1/2 info A/B; here block 0 loads and commits nothing
// - Window 0x40..0x5f holds selected block
// - Host writes 255 minus window byte sum
// - Program flash only after valid checksum
// - Window mode zero means general store
// - Label length byte readable in every mode
// - Label characters readable in every mode
// - Host keeps off reserved tail region
// - Host splits parameter offset into block/byte
// - Window writes past 32 bytes discarded
// - No range checks; store survives reset
// - Two 32-byte info blocks, 64 bytes
// - Subclass 58 block 1 reaches info B
// - Info block loaded, written back on commit
// - Sealed: no general, A read-only, B R/W
// - Three modes; key class needs full access
// - Dedicated reads stay open when sealed
// - Sealed flag cleared by two-word key
`timescale 1ns/10ps
`default_nettype none
`include "nvw_cfg.svh"
module nvw_device
  import nvw_pkg::*;
#(
  parameter int GEN_AW = 4,
  parameter logic [15:0] PACK_WORD = 16'h0000,
  parameter logic [15:0] CAPACITY = 16'h0000,
  parameter logic [7:0] LABEL_LEN = 8'h0a,
  parameter logic [79:0] LABEL_TEXT = 80'h0,
  parameter logic [15:0] UNSEAL_K1 = 16'h1234, // Arbitrary value
  parameter logic [15:0] UNSEAL_K0 = 16'h5678, // Arbitrary value
  parameter logic [15:0] FULL_K1 = 16'hffff, // Arbitrary value
  parameter logic [15:0] FULL_K0 = 16'hffff, // Arbitrary value
  parameter logic [7:0] KEY_SUBCLASS = 8'h70 // Arbitrary value
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  nvw_if.device link,
  output logic sealed_out,
  output logic busy_out
);
  // ************************************************
  // Storage and state
  // ************************************************
  logic [7:0] gen_mem [2**(GEN_AW+5)];
  logic [7:0] mib_mem [2*`NVW_WIN_BYTES];
  logic [7:0] win [`NVW_WIN_BYTES];
  nvw_sec_type sec;
  nvw_dev_state_type state;
  logic [7:0] subclass;
  logic [7:0] block;
  logic [7:0] mode;
  logic [7:0] sum_byte;
  logic [7:0] ctl_lo;
  logic [15:0] ctl_prev;
  logic [4:0] cnt;
  logic [5:0] run;
  logic overrun;
  logic [7:0] rd;
  logic [7:0] win_sum;
  logic mib_path;
  logic to_mib;
  logic to_none;
  logic mib_b;
  logic may_commit;
  logic take;
  logic [4:0] widx;
  logic [15:0] ctl_word;
  logic [GEN_AW-1:0] gidx;

  assign take = link.req && !link.ack && state == NVW_IDLE;
  assign widx = link.addr[4:0];
  assign ctl_word = {link.wdata, ctl_lo};
  assign gidx = GEN_AW'({subclass, block[1:0]});

  // ************************************************
  // Block routing and commit permission
  // ************************************************
  always_comb begin
    mib_path = sec == NVW_SEALED || mode != 8'h00;
    to_mib = 1'b0;
    to_none = 1'b0;
    mib_b = 1'b0;
    if (mib_path) begin
      to_mib = block == 8'h01 || block == 8'h02;
      to_none = !to_mib;
      mib_b = block == 8'h02;
    end else if (subclass == `NVW_MIB_SUBCLASS && block <= 8'h01) begin
      to_mib = 1'b1;
      mib_b = block[0];
    end
    // Sealed keeps info A read-only; only B and open paths commit
    may_commit = !to_none && !overrun;
    if (sec == NVW_SEALED && !(to_mib && mib_b)) begin
      may_commit = 1'b0;
    end
    if (!to_mib && subclass == KEY_SUBCLASS && sec != NVW_FULL) begin
      may_commit = 1'b0;
    end
  end

  // Byte-wise sum of the window
  always_comb begin
    win_sum = 8'h00;
    for (int i = 0; i < `NVW_WIN_BYTES; i++) begin
      win_sum = win_sum + win[i];
    end
  end

  // ************************************************
  // Read data mux
  // ************************************************
  always_comb begin
    rd = 8'h00;
    if (link.addr == `NVW_A_CTL_LO) begin
      rd = 8'h00;
      rd[`NVW_ST_SEALED] = sec == NVW_SEALED;
      rd[`NVW_ST_FULL] = sec == NVW_FULL;
    end else if (link.addr == `NVW_A_PACK_LO) begin
      rd = PACK_WORD[7:0];
    end else if (link.addr == `NVW_A_PACK_HI) begin
      rd = PACK_WORD[15:8];
    end else if (link.addr == `NVW_A_CAP_LO) begin
      rd = CAPACITY[7:0];
    end else if (link.addr == `NVW_A_CAP_HI) begin
      rd = CAPACITY[15:8];
    end else if (link.addr == `NVW_A_SUBCLASS) begin
      rd = sec == NVW_SEALED ? 8'h00 : subclass;
    end else if (link.addr == `NVW_A_BLOCK) begin
      rd = block;
    end else if (link.addr >= `NVW_A_WIN_LO && link.addr <= `NVW_A_WIN_HI) begin
      rd = win[widx];
    end else if (link.addr == `NVW_A_SUM) begin
      rd = sum_byte;
    end else if (link.addr == `NVW_A_MODE) begin
      rd = sec == NVW_SEALED ? 8'h00 : mode;
    end else if (link.addr == `NVW_A_LABEL_LEN) begin
      rd = LABEL_LEN;
    end else if (link.addr >= `NVW_A_LABEL_LO && link.addr <= `NVW_A_LABEL_HI) begin
      rd = LABEL_TEXT[8*(7'(link.addr - `NVW_A_LABEL_LO))+:8];
    end
  end

  // ************************************************
  // Link answer
  // ************************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      link.ack <= 1'b0;
      link.rdata <= 8'h00;
    end else begin
      link.ack <= take;
      if (take) begin
        link.rdata <= link.we ? 8'h00 : rd;
      end
    end
  end

  // Security mode; control word arrives low byte then high byte
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sec <= NVW_SEALED;
      ctl_lo <= 8'h00;
      ctl_prev <= 16'h0000;
    end else if (take && link.we && link.addr == `NVW_A_CTL_LO) begin
      ctl_lo <= link.wdata;
    end else if (take && link.we && link.addr == `NVW_A_CTL_HI) begin
      ctl_prev <= ctl_word;
      if (ctl_word == `NVW_SEAL_SUBCMD) begin
        sec <= NVW_SEALED;
      end else if (sec == NVW_SEALED && ctl_prev == UNSEAL_K1 && ctl_word == UNSEAL_K0) begin
        sec <= NVW_OPEN;
      end else if (sec == NVW_OPEN && ctl_prev == FULL_K1 && ctl_word == FULL_K0) begin
        sec <= NVW_FULL;
      end
    end
  end

  // ************************************************
  // Selects, checksum byte and run guard
  // ************************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      subclass <= 8'h00;
      block <= 8'h00;
      mode <= 8'h00;
      sum_byte <= 8'h00;
      run <= 6'd0;
      overrun <= 1'b0;
    end else if (take) begin
      run <= 6'd0;
      if (link.we && link.addr == `NVW_A_SUBCLASS && sec != NVW_SEALED) begin
        subclass <= link.wdata;
        overrun <= 1'b0;
      end
      if (link.we && link.addr == `NVW_A_BLOCK) begin
        block <= link.wdata;
        overrun <= 1'b0;
      end
      if (link.we && link.addr == `NVW_A_MODE && sec != NVW_SEALED) begin
        mode <= link.wdata;
        overrun <= 1'b0;
      end
      if (link.we && link.addr == `NVW_A_SUM) begin
        sum_byte <= link.wdata;
      end
      if (link.we && link.addr >= `NVW_A_WIN_LO && link.addr <= `NVW_A_WIN_HI) begin
        // A run of window writes longer than one block poisons the data
        run <= run == 6'(`NVW_WIN_BYTES) ? run : run + 6'd1;
        if (run == 6'(`NVW_WIN_BYTES)) begin
          overrun <= 1'b1;
        end
      end
    end
  end

  // ************************************************
  // Load / program sequencer
  // ************************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= NVW_LOAD;
      cnt <= 5'd0;
    end else begin
      unique case (state)
        NVW_IDLE: begin
          cnt <= 5'd0;
          if (take && link.we && (link.addr == `NVW_A_BLOCK
              || (link.addr == `NVW_A_SUBCLASS && sec != NVW_SEALED)
              || (link.addr == `NVW_A_MODE && sec != NVW_SEALED))) begin
            state <= NVW_LOAD;
          end else if (take && link.we && link.addr == `NVW_A_SUM && may_commit
              && link.wdata == `NVW_SUM_BASE - win_sum) begin
            state <= NVW_PROG;
          end
        end
        NVW_LOAD, NVW_PROG: begin
          cnt <= cnt + 5'd1;
          if (cnt == 5'(`NVW_WIN_BYTES - 1)) begin
            state <= NVW_IDLE;
          end
        end
      endcase
    end
  end

  // Window contents: host writes, or one byte per cycle while loading
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < `NVW_WIN_BYTES; i++) begin
        win[i] <= 8'h00;
      end
    end else if (state == NVW_LOAD) begin
      if (to_mib) begin
        win[cnt] <= mib_mem[{mib_b, cnt}];
      end else if (!to_none) begin
        win[cnt] <= gen_mem[{gidx, cnt}];
      end
    end else if (take && link.we && link.addr >= `NVW_A_WIN_LO
        && link.addr <= `NVW_A_WIN_HI && run != 6'(`NVW_WIN_BYTES)) begin
      win[widx] <= link.wdata;
    end
  end

  // Store has no reset so its contents outlive any reset
  always_ff @(posedge clk_in) begin
    if (state == NVW_PROG) begin
      if (to_mib) begin
        mib_mem[{mib_b, cnt}] <= win[cnt];
      end else begin
        gen_mem[{gidx, cnt}] <= win[cnt];
      end
    end
  end

  // Status pins
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sealed_out <= 1'b1;
      busy_out <= 1'b1;
    end else begin
      sealed_out <= sec == NVW_SEALED;
      busy_out <= state != NVW_IDLE;
    end
  end
endmodule
`default_nettype wire

// [rtl/nvw_cfg.svh]
// Offsets, field positions and constants of the block window
`ifndef NVW_CFG_SVH
`define NVW_CFG_SVH
`define NVW_A_CTL_LO 8'h00
`define NVW_A_CTL_HI 8'h01
`define NVW_A_PACK_LO 8'h3a
`define NVW_A_PACK_HI 8'h3b
`define NVW_A_CAP_LO 8'h3c
`define NVW_A_CAP_HI 8'h3d
`define NVW_A_SUBCLASS 8'h3e
`define NVW_A_BLOCK 8'h3f
`define NVW_A_WIN_LO 8'h40
`define NVW_A_WIN_HI 8'h5f
`define NVW_A_SUM 8'h60
`define NVW_A_MODE 8'h61
`define NVW_A_LABEL_LEN 8'h62
`define NVW_A_LABEL_LO 8'h63
`define NVW_A_LABEL_HI 8'h6c
`define NVW_A_RSVD_HI 8'h7f
`define NVW_WIN_BYTES 32
`define NVW_SUM_BASE 8'hff
`define NVW_MIB_SUBCLASS 8'd58
`define NVW_SEAL_SUBCMD 16'h0020
`define NVW_ST_SEALED 0
`define NVW_ST_FULL 1
// Host register map
`define NVW_R_CMD 12'h000
`define NVW_R_STATUS 12'h004
`define NVW_CMD_WE 16
`define NVW_CMD_KIND_LSB 17
`define NVW_STS_BUSY 8
`define NVW_STS_REFUSED 9
`define NVW_STS_SEALED 10
`endif

// [rtl/nvw_pkg.sv]
// Types shared by both ends of the block window link
package nvw_pkg;
  typedef enum logic [2:0] {
    NVW_FULL = 3'b001,
    NVW_OPEN = 3'b010,
    NVW_SEALED = 3'b100
  } nvw_sec_type;
  typedef enum logic [2:0] {
    NVW_IDLE = 3'b001,
    NVW_LOAD = 3'b010,
    NVW_PROG = 3'b100
  } nvw_dev_state_type;
  typedef enum logic [1:0] {
    NVW_H_IDLE = 2'b01,
    NVW_H_WAIT = 2'b10
  } nvw_host_state_type;
  typedef enum logic [1:0] {
    NVW_K_RAW = 2'd0,
    NVW_K_PARAM = 2'd1,
    NVW_K_COMMIT = 2'd2
  } nvw_kind_type;
endpackage

// [rtl/nvw_if.sv]
// Byte command link between host processor and gauge window
`timescale 1ns/10ps
`default_nettype none
interface nvw_if;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  modport host (output req, output we, output addr, output wdata, input ack, input rdata);
  modport device (input req, input we, input addr, input wdata, output ack, output rdata);
endinterface
`default_nettype wire

// [rtl/nvw_host.sv]
// Host end: APB-programmed sequencer driving the gauge window link
`timescale 1ns/10ps
`default_nettype none
`include "nvw_cfg.svh"
module nvw_host
  import nvw_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  nvw_if.host link
);
  // ************************************************
  // State
  // ************************************************
  nvw_host_state_type state;
  logic [7:0] shadow [`NVW_WIN_BYTES];
  logic [7:0] shadow_sum;
  logic [7:0] last_rdata;
  logic refused;
  logic sealed_seen;
  logic pend;
  logic [7:0] pend_addr;
  logic [7:0] pend_wdata;
  logic pend_we;
  logic wr_cmd;
  logic mapped;
  logic [7:0] c_addr;
  logic [7:0] c_data;
  nvw_kind_type c_kind;
  logic bad;

  assign mapped = paddr_in == `NVW_R_CMD || paddr_in == `NVW_R_STATUS;
  assign wr_cmd = psel_in && penable_in && pready_out && pwrite_in && paddr_in == `NVW_R_CMD;
  assign c_addr = pwdata_in[7:0];
  assign c_data = pwdata_in[15:8];
  assign c_kind = nvw_kind_type'(pwdata_in[`NVW_CMD_KIND_LSB+:2]);
  // Reserved tail and sealed-only-absent selects are never sent
  assign bad = c_kind != NVW_K_PARAM && c_kind != NVW_K_COMMIT
      && ((c_addr > `NVW_A_LABEL_HI)
      || (sealed_seen && pwdata_in[`NVW_CMD_WE]
      && (c_addr == `NVW_A_SUBCLASS || c_addr == `NVW_A_MODE)));

  always_comb begin
    shadow_sum = 8'h00;
    for (int i = 0; i < `NVW_WIN_BYTES; i++) begin
      shadow_sum = shadow_sum + shadow[i];
    end
  end

  // ************************************************
  // APB slave; one setup plus one access cycle
  // ************************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0;
    end else begin
      pready_out <= psel_in && !penable_in;
      pslverr_out <= psel_in && !penable_in && !mapped;
      prdata_out <= 32'h0;
      if (psel_in && !penable_in && paddr_in == `NVW_R_STATUS) begin
        prdata_out[7:0] <= last_rdata;
        prdata_out[`NVW_STS_BUSY] <= state != NVW_H_IDLE;
        prdata_out[`NVW_STS_REFUSED] <= refused;
        prdata_out[`NVW_STS_SEALED] <= sealed_seen;
      end
    end
  end

  // ************************************************
  // Link sequencer; a command is ignored while busy
  // ************************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= NVW_H_IDLE;
      link.req <= 1'b0;
      link.we <= 1'b0;
      link.addr <= 8'h00;
      link.wdata <= 8'h00;
      pend <= 1'b0;
      pend_addr <= 8'h00;
      pend_wdata <= 8'h00;
      pend_we <= 1'b0;
      refused <= 1'b0;
    end else begin
      unique case (state)
        NVW_H_IDLE: begin
          if (wr_cmd && bad) begin
            refused <= 1'b1;
          end else if (wr_cmd) begin
            refused <= 1'b0;
            state <= NVW_H_WAIT;
            link.req <= 1'b1;
            pend <= c_kind == NVW_K_PARAM;
            pend_addr <= `NVW_A_WIN_LO + {3'b000, c_addr[4:0]};
            pend_wdata <= c_data;
            pend_we <= pwdata_in[`NVW_CMD_WE];
            if (c_kind == NVW_K_PARAM) begin
              link.we <= 1'b1;
              link.addr <= `NVW_A_BLOCK;
              link.wdata <= {5'b00000, c_addr[7:5]};
            end else if (c_kind == NVW_K_COMMIT) begin
              link.we <= 1'b1;
              link.addr <= `NVW_A_SUM;
              link.wdata <= `NVW_SUM_BASE - shadow_sum;
            end else begin
              link.we <= pwdata_in[`NVW_CMD_WE];
              link.addr <= c_addr;
              link.wdata <= c_data;
            end
          end
        end
        NVW_H_WAIT: begin
          if (link.ack && pend) begin
            // Second step only after the device has refreshed its window
            link.req <= 1'b0;
            pend <= 1'b0;
            link.we <= pend_we;
            link.addr <= pend_addr;
            link.wdata <= pend_wdata;
          end else if (!link.req) begin
            link.req <= 1'b1;
          end else if (link.ack) begin
            link.req <= 1'b0;
            state <= NVW_H_IDLE;
          end
        end
      endcase
    end
  end

  // Window shadow, read data and sealed flag follow each completed access
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < `NVW_WIN_BYTES; i++) begin
        shadow[i] <= 8'h00;
      end
      last_rdata <= 8'h00;
      sealed_seen <= 1'b1;
    end else if (link.req && link.ack) begin
      if (!link.we) begin
        last_rdata <= link.rdata;
      end
      if (link.addr >= `NVW_A_WIN_LO && link.addr <= `NVW_A_WIN_HI) begin
        shadow[link.addr[4:0]] <= link.we ? link.wdata : link.rdata;
      end
      if (!link.we && link.addr == `NVW_A_CTL_LO) begin
        sealed_seen <= link.rdata[`NVW_ST_SEALED];
      end
    end
  end
endmodule
`default_nettype wire

// [tb/nvw_link_asserts.sv]
// Link protocol and fixed-register checks for the block window
`timescale 1ns/10ps
`default_nettype none
module nvw_link_asserts #(
  parameter logic [15:0] PACK_WORD = 16'h0000,
  parameter logic [15:0] CAPACITY = 16'h0000,
  parameter logic [7:0] LABEL_LEN = 8'h0a
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata,
  input wire logic sealed_out,
  input wire logic busy_out
);
  logic [3:0] since_ctl;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Cycles since a control high byte; saturates so a long run cannot wrap
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      since_ctl <= 4'hf;
    end else if (ack && we && addr == 8'h01) begin
      since_ctl <= 4'h0;
    end else if (since_ctl != 4'hf) begin
      since_ctl <= since_ctl + 4'h1;
    end
  end
  // ****************************************
  // Handshake
  // ****************************************
  req_hold_a: assert property (req && !ack |=> req && $stable(addr) && $stable(we) && $stable(wdata))
    else $error("request changed before its answer");
  ack_drop_a: assert property (ack |=> !ack && !req)
    else $error("answer or request outlived one cycle");
  ack_bound_a: assert property ($rose(req) |-> ##[1:100] ack)
    else $error("request left unanswered");
  write_quiet_a: assert property (ack && we |-> rdata == 8'h00)
    else $error("read byte not cleared on a write answer");
  rsvd_keep_a: assert property (req |-> addr <= 8'h6c)
    else $error("request reached the reserved tail");
  // ****************************************
  // Fixed registers and window reload
  // ****************************************
  pack_word_a: assert property (ack && !we && addr inside {8'h3a, 8'h3b} |->
    rdata == (addr[0] ? PACK_WORD[15:8] : PACK_WORD[7:0])) else $error("pack word byte wrong");
  capacity_a: assert property (ack && !we && addr inside {8'h3c, 8'h3d} |->
    rdata == (addr[0] ? CAPACITY[15:8] : CAPACITY[7:0])) else $error("capacity byte wrong");
  label_len_a: assert property (ack && !we && addr == 8'h62 |-> rdata == LABEL_LEN)
    else $error("label length wrong");
  select_reload_a: assert property (ack && we && addr == 8'h3f |-> ##[1:3] busy_out)
    else $error("block select did not start a reload");
  busy_quiet_a: assert property (busy_out && $past(busy_out) && $past(busy_out, 2) |-> !ack)
    else $error("answer given during a reload");
  unseal_cause_a: assert property ($fell(sealed_out) |-> since_ctl <= 4'h4)
    else $error("sealed flag cleared without a control word");
endmodule
`default_nettype wire

// [tb/nv_block_access_window_bench.sv]
// Self-checking bench: APB-driven host end against the gauge end
`timescale 1ns/10ps
`default_nettype none
module nv_block_access_window_bench
  import nvw_pkg::*;
;
  localparam logic [15:0] PACK = 16'ha5c3;
  localparam logic [15:0] CAP = 16'h0bb8;
  localparam logic [79:0] LBL = 80'h41424344454544434241; // Mirrored: byte order cannot matter
  logic clk_in, rst_n_in, psel, penable, pwrite, pready, pslverr, perr, sealed, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, prd;
  logic [7:0] win[32], keepa[32], keepb[32], w0;
  logic [7:0] expq[$];
  int num_errors = 0;
  int checks_done = 0;
  int seed_v;
  nvw_if nvw_if_i();
  nvw_host nvw_host_i(.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .link(nvw_if_i.host));
  nvw_device #(.PACK_WORD(PACK), .CAPACITY(CAP), .LABEL_TEXT(LBL)) nvw_device_i(
    .clk_in(clk_in), .rst_n_in(rst_n_in), .link(nvw_if_i.device), .sealed_out(sealed),
    .busy_out(busy));
  nvw_link_asserts #(.PACK_WORD(PACK), .CAPACITY(CAP)) nvw_link_asserts_i(.clk_in(clk_in),
    .rst_n_in(rst_n_in), .req(nvw_if_i.req), .we(nvw_if_i.we), .addr(nvw_if_i.addr),
    .wdata(nvw_if_i.wdata), .ack(nvw_if_i.ack), .rdata(nvw_if_i.rdata), .sealed_out(sealed),
    .busy_out(busy));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d errors=%0d pending=%0d", checks_done, num_errors, expq.size());
    if (num_errors == 0 && checks_done > 0 && expq.size() == 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    prd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      conclude();
    end
  endtask
  // Host drops commands while busy, so every command waits for idle status
  task automatic cmd(input nvw_kind_type k, input logic w, input logic [7:0] a,
    input logic [7:0] d);
    int n;
    n = 0;
    apb(1'b1, 12'h000, {13'h0, k, w, d, a});
    do begin
      apb(1'b0, 12'h004, 32'h0);
      n++;
    end while (prd[8] !== 1'b0 && n < 100);
    if (n >= 100) begin
      num_errors++;
      conclude();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    cmd(NVW_K_RAW, 1'b0, a, 8'h00);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cmd(NVW_K_RAW, 1'b1, a, d);
  endtask
  task automatic fill();
    foreach (win[i]) begin
      win[i] = 8'($urandom);
      wr(8'(8'h40 + i), win[i]);
    end
  endtask
  task automatic rdall();
    foreach (win[i]) rd(8'(8'h40 + i), win[i]);
  endtask
  function automatic logic [7:0] csum();
    logic [7:0] s;
    s = 8'h00;
    foreach (win[i]) s = s + win[i];
    return 8'hff - s;
  endfunction
  task automatic do_reset();
    rst_n_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
  endtask
  // ****************************************
  // Clock, monitor, watchdog
  // ****************************************
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  // Every read answer on the link consumes the oldest expectation
  always @(posedge clk_in) begin
    if (nvw_if_i.ack === 1'b1 && nvw_if_i.we === 1'b0) begin
      if (expq.size() == 0) check({24'h0, nvw_if_i.rdata}, 32'hffff_ffff);
      else check({24'h0, nvw_if_i.rdata}, {24'h0, expq.pop_front()});
    end
  end
  initial begin
    #200000;
    num_errors++;
    conclude();
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    seed_v = $urandom(87);
    {psel, penable, pwrite, paddr, pwdata} = '0;
    rst_n_in = 1'b0;
    do_reset();
    for (int i = 0; i < 2; i++) begin
      rd(8'(8'h3a + i), PACK[8*i +: 8]);
      rd(8'(8'h3c + i), CAP[8*i +: 8]);
    end
    rd(8'h62, 8'h0a);
    for (int i = 0; i < 10; i++) rd(8'(8'h63 + i), LBL[79-8*i -: 8]);
    rd(8'h00, 8'h01);
    check(prd[10], 1'b1);
    for (int j = 0; j < 3; j++) begin
      wr(j == 0 ? 8'h3e : (j == 1 ? 8'h61 : 8'h70), 8'h16);
      check(prd[9], 1'b1);
    end
    apb(1'b0, 12'h008, 32'h0);
    check(perr, 1'b1);
    // Sealed: info B is writable, commit needs the complemented sum
    wr(8'h3f, 8'h02);
    check(prd[9], 1'b0);
    fill();
    cmd(NVW_K_COMMIT, 1'b1, 8'h60, 8'h00);
    wr(8'h3f, 8'h02);
    rdall();
    keepb = win;
    wr(8'h45, ~win[5]);
    wr(8'h60, csum());
    wr(8'h3f, 8'h02);
    rd(8'h45, win[5]);
    fill();
    wr(8'h40, ~win[0]);
    rd(8'h40, win[0]);
    // Overrun poisons the block: commit refused, info B keeps its old bytes
    wr(8'h60, csum());
    wr(8'h3f, 8'h02);
    win = keepb;
    rdall();
    // Two key words, low byte first, clear the sealed state
    wr(8'h00, 8'h34);
    wr(8'h01, 8'h12);
    wr(8'h00, 8'h78);
    wr(8'h01, 8'h56);
    check(sealed, 1'b0);
    rd(8'h00, 8'h00);
    check(prd[10], 1'b0);
    wr(8'h61, 8'h00);
    wr(8'h3e, 8'd58);
    wr(8'h3f, 8'h00);
    fill();
    cmd(NVW_K_COMMIT, 1'b1, 8'h60, 8'h00);
    keepa = win;
    expq.push_back(keepb[1]);
    cmd(NVW_K_PARAM, 1'b0, 8'd33, 8'h00);
    wr(8'h3e, 8'h22);
    wr(8'h3f, 8'h02);
    fill();
    cmd(NVW_K_COMMIT, 1'b1, 8'h60, 8'h00);
    wr(8'h3f, 8'h00);
    wr(8'h3f, 8'h02);
    rdall();
    // Nonzero window mode routes the block select to the info blocks
    wr(8'h61, 8'h01);
    wr(8'h3f, 8'h02);
    rd(8'h5f, keepb[31]);
    // Stored blocks survive reset; info A is read-only while sealed
    do_reset();
    check(sealed, 1'b1);
    wr(8'h3f, 8'h01);
    win = keepa;
    rdall();
    w0 = win[0];
    win[0] = ~w0;
    wr(8'h40, win[0]);
    wr(8'h60, csum());
    wr(8'h3f, 8'h01);
    rd(8'h40, w0);
    wr(8'h3f, 8'h02);
    win = keepb;
    rdall();
    conclude();
  end
endmodule
`default_nettype wire
